// ---- core/tdo_pkg.sv ----
// Shared constants and types for the T1 receive overhead block
package tdo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map of the parallel port
  localparam logic [7:0] ADDR_CODE_CTRL = 8'h15;
  localparam logic [7:0] ADDR_DL_SHIFT = 8'h62;
  localparam logic [7:0] ADDR_CODE_VAL = 8'h63;
  localparam logic [7:0] ADDR_CARRIER_1 = 8'h64;
  localparam logic [7:0] ADDR_CARRIER_2 = 8'h65;
  localparam logic [7:0] ADDR_CARRIER_3 = 8'h66;
  localparam logic [7:0] ADDR_LSTAT7 = 8'h70;
  localparam logic [7:0] ADDR_IMASK7 = 8'h71;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam logic [7:0] CTRL_WR_MASK = 8'hB6;
  localparam int CTRL_FILT_LSB = 1;
  localparam int CTRL_DISINT_LSB = 4;
  localparam int CTRL_RESET_BIT = 7;
  localparam int STAT_CODE_DET = 0;
  localparam int STAT_CODE_CLR = 1;
  localparam int STAT_DL_FULL = 2;
  localparam int STAT_CARRIER = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Line-side framing constants and counts
  localparam logic [7:0] CODE_FLAG = 8'hFF;
  localparam logic [11:0] CARRIER_ALIGN = 12'hE38;
  localparam int CARRIER_1_LSB = 12;
  localparam int CARRIER_2_LSB = 20;
  localparam int CARRIER_3_LSB = 28;
  localparam logic [2:0] DL_LAST_BIT = 3'h7;
  localparam logic [6:0] DISINT_STEP = 7'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {CD_HUNT = 2'b01, CD_HOLD = 2'b10} tdo_cd_state_t;

  typedef struct packed {
    logic dl_stb;
    logic dl_bit;
    logic sf_last;
    logic mf_last;
  } tdo_ovh_t;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tdo_pbus_t;

  typedef struct packed {
    logic [1:0] disint;
    logic [1:0] filt;
  } tdo_code_cfg_t;

  ////////////////////////////////////////////////////////////////////////////
  // Settings decoders
  function automatic logic [2:0] filt_need(input logic [1:0] sel);
    case (sel)
      2'h0: filt_need = 3'h1;
      2'h1: filt_need = 3'h3;
      2'h2: filt_need = 3'h5;
      default: filt_need = 3'h7;
    endcase
  endfunction

  function automatic logic [6:0] disint_bits(input logic [1:0] sel);
    disint_bits = DISINT_STEP * ({5'h00, sel} + 7'h01);
  endfunction

endpackage

// ---- core/tdo_code_det.sv ----
// Bit-oriented code detector with integrate and clear filters
`timescale 1ns/1ps
`default_nettype none
module tdo_code_det
  import tdo_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Message bits
  input wire logic en,
  input wire logic bit_stb,
  input wire logic bit_in,
  // Settings and reset from the control register
  input wire tdo_code_cfg_t cfg_new,
  input wire logic soft_rst,
  // Results
  output logic det_stb,
  output logic clr_stb,
  output logic [5:0] code
);

  typedef struct packed {
    logic [15:0] shift;
    tdo_code_cfg_t cfg;
    tdo_cd_state_t st;
    logic [5:0] cand;
    logic [2:0] cnt;
    logic [6:0] idle;
    logic [5:0] code;
    logic det;
    logic clr;
  } tdo_cd_st_t;

  tdo_cd_st_t q;
  tdo_cd_st_t d;
  logic [15:0] sh;
  logic valid;
  logic [2:0] cnt1;

  always_comb begin
    d = q;
    d.det = 1'b0;
    d.clr = 1'b0;
    sh = {q.shift[14:0], bit_in};
    valid = (sh[15:8] == CODE_FLAG) && !sh[7] && !sh[0];
    cnt1 = (q.cnt != 3'h0 && sh[6:1] == q.cand) ? q.cnt + 3'h1 : 3'h1;
    if (soft_rst) begin
      d.cfg = cfg_new;
      d.st = CD_HUNT;
      d.cnt = 3'h0;
      d.idle = 7'h00;
      d.shift = 16'h0000;
    end else if (en && bit_stb) begin
      d.shift = valid ? 16'h0000 : sh;
      case (q.st)
        CD_HUNT: begin
          if (valid) begin
            d.cand = sh[6:1];
            d.cnt = cnt1;
            if (cnt1 >= filt_need(q.cfg.filt)) begin
              d.st = CD_HOLD;
              d.code = sh[6:1];
              d.det = 1'b1;
              d.cnt = 3'h0;
              d.idle = 7'h00;
            end
          end
        end
        CD_HOLD: begin
          if (valid && sh[6:1] == q.code) begin
            d.idle = 7'h00;
          end else if (q.idle + 7'h01 == disint_bits(q.cfg.disint)) begin
            d.clr = 1'b1;
            d.st = CD_HUNT;
            d.idle = 7'h00;
          end else begin
            d.idle = q.idle + 7'h01;
          end
        end
        default: d.st = CD_HUNT;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.st <= CD_HUNT;
    end else begin
      q <= d;
    end
  end

  assign det_stb = q.det;
  assign clr_stb = q.clr;
  assign code = q.code;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_cfg_hold;
    @(posedge ref_clk) disable iff (!arst_n)
      !soft_rst |=> $stable(q.cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("filter settings changed without a reset");

  property p_det_count;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(q.st == CD_HOLD) |-> q.det &&
        ({1'b0, $past(q.cnt)} + 4'h1 >= {1'b0, filt_need(q.cfg.filt)});
  endproperty
  a_det_count: assert property (p_det_count)
    else $error("code reported before the filter count");

  property p_clr_idle;
    @(posedge ref_clk) disable iff (!arst_n)
      q.clr |-> $past(q.idle) == disint_bits(q.cfg.disint) - 7'h01;
  endproperty
  a_clr_idle: assert property (p_clr_idle)
    else $error("clear reported at the wrong bit count");

  property p_no_integ_hold;
    @(posedge ref_clk) disable iff (!arst_n)
      q.st == CD_HOLD |-> q.cnt == 3'h0 && !$rose(q.clr & q.det);
  endproperty
  a_no_integ_hold: assert property (p_no_integ_hold)
    else $error("integration running while disintegrating");

endmodule
`default_nettype wire

// ---- core/tdo_rx_overhead.sv ----
// T1 receive overhead: code detector, carrier link capture, data link shift
//
// Behaviour
// - Code detection only in T1 extended superframe
// - Flag after 1/3/5/7 identical error-free codes
// - Cleared flag stays clear until new detection
// - Clear flag after 16/32/48/64 bits without code
// - Interrupt low on unmasked detect or clear
// - Zero-to-one control bit 7 resets detector
// - Filter settings take effect after detector reset
// - No concurrent integrating and disintegrating
// - Code register holds last code, bits 0-5
// - Carrier multiframe is 72 frames, 36 bits
// - Carrier flag after alignment and register update
// - No carrier flag without alignment pattern
// - Carrier registers hold concentrator to spoiler fields
// - Link bits shift into 8-bit register
// - Full flag bit 2, masked interrupt
// - No zero-bit destuffing of link bits
// - First link bit in bit 0
// - Superframe mode updates six bits at each superframe end
`timescale 1ns/1ps
`default_nettype none
module tdo_rx_overhead
  import tdo_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Port mode from the framer configuration
  input wire logic t1_mode,
  input wire logic esf_mode,
  // Overhead bits from the receive framer
  input wire tdo_ovh_t ovh,
  // Parallel register port pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] d_in,
  output logic [7:0] d_out,
  output logic d_oe_n,
  // Interrupt pin
  output logic int_n
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    tdo_pbus_t s1;
    tdo_pbus_t s2;
    logic wr_prev;
    logic [7:0] ctl;
    logic rst_p;
    logic [3:0] mask;
    logic [3:0] stat;
    logic [7:0] dl_sh;
    logic [2:0] dl_cnt;
    logic [7:0] dl_reg;
    logic [35:0] fs_win;
    logic [7:0] slc1;
    logic [7:0] slc2;
    logic [7:0] slc3;
    logic [7:0] rdata;
    logic oe_n;
    logic int_n;
  } tdo_top_st_t;

  tdo_top_st_t q;
  tdo_top_st_t d;
  tdo_pbus_t pins;
  logic wr_go;
  logic [3:0] stat_set;
  logic [3:0] stat_clr;
  logic [35:0] win_nx;
  logic [7:0] sh_nx;
  logic esf_ev;
  logic d4_ev;
  logic code_det;
  logic code_clr;
  logic [5:0] code_val;
  tdo_code_cfg_t cfg_new;

  // Strobes are stored active high so a cleared synchroniser is idle
  assign pins = '{cs: ~cs_n, rd: ~rd_n, wr: ~wr_n, addr: addr, wdata: d_in};

  assign cfg_new = '{disint: q.ctl[CTRL_DISINT_LSB +: 2],
                     filt: q.ctl[CTRL_FILT_LSB +: 2]};

  ////////////////////////////////////////////////////////////////////////////
  // Code detector

  tdo_code_det u_code_det (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .en(t1_mode && esf_mode),
    .bit_stb(ovh.dl_stb),
    .bit_in(ovh.dl_bit),
    .cfg_new(cfg_new),
    .soft_rst(q.rst_p),
    .det_stb(code_det),
    .clr_stb(code_clr),
    .code(code_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.wr_prev = q.s2.wr;
    d.rst_p = 1'b0;
    stat_set = RST_NIBBLE;
    stat_clr = RST_NIBBLE;
    // Write lands as the strobe falls away, so data has settled by then
    wr_go = q.wr_prev && !q.s2.wr && q.s2.cs;

    if (wr_go) begin
      case (q.s2.addr)
        ADDR_CODE_CTRL: begin
          d.ctl = q.s2.wdata & CTRL_WR_MASK;
          d.rst_p = q.s2.wdata[CTRL_RESET_BIT] & ~q.ctl[CTRL_RESET_BIT];
        end
        ADDR_LSTAT7: stat_clr = q.s2.wdata[3:0];
        ADDR_IMASK7: d.mask = q.s2.wdata[3:0];
        default: ;
      endcase
    end

    stat_set[STAT_CODE_DET] = code_det;
    stat_set[STAT_CODE_CLR] = code_clr;

    esf_ev = t1_mode && esf_mode && ovh.dl_stb;
    d4_ev = t1_mode && !esf_mode && ovh.dl_stb;

    // first bit ends in bit 0
    sh_nx = {ovh.dl_bit, q.dl_sh[7:1]};
    if (esf_ev) begin
      d.dl_sh = sh_nx;
      d.dl_cnt = q.dl_cnt + 3'h1;
      if (q.dl_cnt == DL_LAST_BIT) begin
        d.dl_reg = sh_nx;
        stat_set[STAT_DL_FULL] = 1'b1;
      end
    end

    if (d4_ev) begin
      d.dl_sh = {2'h0, ovh.dl_bit, q.dl_sh[5:1]};
      d.dl_cnt = 3'h0;
      if (ovh.sf_last) begin
        d.dl_reg = {2'h0, ovh.dl_bit, q.dl_sh[5:1]};
        stat_set[STAT_DL_FULL] = 1'b1;
      end
    end

    win_nx = {ovh.dl_bit, q.fs_win[35:1]};
    if (d4_ev) begin
      d.fs_win = win_nx;
      if (ovh.mf_last && win_nx[11:0] == CARRIER_ALIGN) begin
        d.slc1 = win_nx[CARRIER_1_LSB +: 8];
        d.slc2 = win_nx[CARRIER_2_LSB +: 8];
        d.slc3 = win_nx[CARRIER_3_LSB +: 8];
        stat_set[STAT_CARRIER] = 1'b1;
      end
    end

    d.stat = (q.stat & ~stat_clr) | stat_set;
    d.int_n = ~|(d.stat & d.mask);

    d.oe_n = ~(q.s2.cs && q.s2.rd);
    case (q.s2.addr)
      ADDR_CODE_CTRL: d.rdata = q.ctl;
      ADDR_DL_SHIFT: d.rdata = q.dl_reg;
      ADDR_CODE_VAL: d.rdata = {2'h0, code_val};
      ADDR_CARRIER_1: d.rdata = q.slc1;
      ADDR_CARRIER_2: d.rdata = q.slc2;
      ADDR_CARRIER_3: d.rdata = q.slc3;
      ADDR_LSTAT7: d.rdata = {4'h0, q.stat};
      ADDR_IMASK7: d.rdata = {4'h0, q.mask};
      default: d.rdata = RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.oe_n <= 1'b1;
      q.int_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign d_out = q.rdata;
  assign d_oe_n = q.oe_n;
  assign int_n = q.int_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_int_low;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(q.stat[STAT_CODE_DET]) && q.mask[STAT_CODE_DET] |-> !int_n;
  endproperty
  a_int_low: assert property (p_int_low)
    else $error("detect flag unmasked but interrupt high");

  property p_int_clr;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(q.stat[STAT_CODE_CLR]) && q.mask[STAT_CODE_CLR] |-> !int_n;
  endproperty
  a_int_clr: assert property (p_int_clr)
    else $error("clear flag unmasked but interrupt high");

  property p_dl_full;
    @(posedge ref_clk) disable iff (!arst_n)
      esf_ev && q.dl_cnt == DL_LAST_BIT |=>
        q.stat[STAT_DL_FULL] && q.dl_reg[7] == $past(ovh.dl_bit) &&
        q.dl_reg[0] == $past(q.dl_sh[1]);
  endproperty
  a_dl_full: assert property (p_dl_full)
    else $error("link register full not flagged");

  property p_dl_quiet;
    @(posedge ref_clk) disable iff (!arst_n)
      esf_ev && q.dl_cnt != DL_LAST_BIT |=> $stable(q.dl_reg);
  endproperty
  a_dl_quiet: assert property (p_dl_quiet)
    else $error("link register moved before eight bits");

  property p_d4_fdl;
    @(posedge ref_clk) disable iff (!arst_n)
      d4_ev && ovh.sf_last |=>
        q.dl_reg[7:6] == 2'h0 && q.dl_reg[5] == $past(ovh.dl_bit) &&
        q.stat[STAT_DL_FULL];
  endproperty
  a_d4_fdl: assert property (p_d4_fdl)
    else $error("superframe link update wrong");

  property p_carrier_miss;
    @(posedge ref_clk) disable iff (!arst_n)
      d4_ev && ovh.mf_last && win_nx[11:0] != CARRIER_ALIGN &&
      !q.stat[STAT_CARRIER] |=> !q.stat[STAT_CARRIER] && $stable(q.slc1);
  endproperty
  a_carrier_miss: assert property (p_carrier_miss)
    else $error("carrier flag set without alignment");

  property p_carrier_hit;
    @(posedge ref_clk) disable iff (!arst_n)
      d4_ev && ovh.mf_last && win_nx[11:0] == CARRIER_ALIGN |=>
        q.stat[STAT_CARRIER] && q.slc3[7] == $past(ovh.dl_bit);
  endproperty
  a_carrier_hit: assert property (p_carrier_hit)
    else $error("aligned multiframe not captured");

  property p_stat_sticky;
    @(posedge ref_clk) disable iff (!arst_n)
      q.stat[STAT_DL_FULL] && !stat_clr[STAT_DL_FULL] |=>
        q.stat[STAT_DL_FULL];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky)
    else $error("flag dropped without software clear");

  property p_reset_once;
    @(posedge ref_clk) disable iff (!arst_n)
      wr_go && q.s2.addr == ADDR_CODE_CTRL && q.ctl[CTRL_RESET_BIT] |=>
        !q.rst_p;
  endproperty
  a_reset_once: assert property (p_reset_once)
    else $error("detector reset without a rising control bit");

  property p_no_code_d4;
    @(posedge ref_clk) disable iff (!arst_n)
      !esf_mode ##1 !esf_mode |-> !code_det;
  endproperty
  a_no_code_d4: assert property (p_no_code_d4)
    else $error("code detected outside extended superframe");

  property p_ctl_write;
    @(posedge ref_clk) disable iff (!arst_n)
      wr_go && q.s2.addr == ADDR_CODE_CTRL |=>
        q.ctl == ($past(q.s2.wdata) & CTRL_WR_MASK);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control write not stored");

  property p_reset_rise;
    @(posedge ref_clk) disable iff (!arst_n)
      wr_go && q.s2.addr == ADDR_CODE_CTRL &&
      q.s2.wdata[CTRL_RESET_BIT] && !q.ctl[CTRL_RESET_BIT] |=> q.rst_p;
  endproperty
  a_reset_rise: assert property (p_reset_rise)
    else $error("rising reset bit gave no detector reset");

  property p_int_full;
    @(posedge ref_clk) disable iff (!arst_n)
      q.stat[STAT_DL_FULL] && q.mask[STAT_DL_FULL] |-> !int_n;
  endproperty
  a_int_full: assert property (p_int_full)
    else $error("link full unmasked but interrupt high");

  property p_int_quiet;
    @(posedge ref_clk) disable iff (!arst_n)
      (q.stat & q.mask) == RST_NIBBLE |-> int_n;
  endproperty
  a_int_quiet: assert property (p_int_quiet)
    else $error("interrupt low with no enabled flag");

  property p_carrier_keep;
    @(posedge ref_clk) disable iff (!arst_n)
      !(d4_ev && ovh.mf_last) |=> $stable({q.slc1, q.slc2, q.slc3});
  endproperty
  a_carrier_keep: assert property (p_carrier_keep)
    else $error("carrier registers moved between multiframes");

  property p_stat_clear;
    @(posedge ref_clk) disable iff (!arst_n)
      wr_go && q.s2.addr == ADDR_LSTAT7 |=>
        (q.stat & $past(q.s2.wdata[3:0] & ~stat_set)) == RST_NIBBLE;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("written one did not clear its flag");

  property p_set_wins;
    @(posedge ref_clk) disable iff (!arst_n)
      stat_set != RST_NIBBLE |=>
        (q.stat & $past(stat_set)) == $past(stat_set);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag event lost against a clear");

  property p_code_read;
    @(posedge ref_clk) disable iff (!arst_n)
      q.s2.addr == ADDR_CODE_VAL |=> d_out[7:6] == 2'h0;
  endproperty
  a_code_read: assert property (p_code_read)
    else $error("unused code register bits not zero");

endmodule
`default_nettype wire

// ---- dv/tdo_line_model.sv ----
// Far-end line source that feeds framed overhead bits to the block
`timescale 1ns/1ps
`default_nettype none
module tdo_line_model
  import tdo_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Overhead bits toward the block
  output tdo_ovh_t ovh
);
  initial begin
    ovh = '0;
  end
  task automatic send(input logic b, input logic sl, input logic ml);
    @(negedge ref_clk);
    ovh <= {1'b1, b, sl, ml};
    @(negedge ref_clk);
    // A released bit shows its inverse so stale data is never trusted
    ovh <= {1'b0, ~b, 2'b00};
  endtask
  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      send(v[i], 1'b0, 1'b0);
    end
  endtask
  task automatic send_zeros(input int n);
    repeat (n) send(1'b0, 1'b0, 1'b0);
  endtask
  // Code frame: flag, zero, code with its top bit first, zero
  task automatic send_code(input logic [5:0] c);
    send_byte(CODE_FLAG);
    send(1'b0, 1'b0, 1'b0);
    for (int i = 5; i >= 0; i--) begin
      send(c[i], 1'b0, 1'b0);
    end
    send(1'b0, 1'b0, 1'b0);
  endtask
  // 36 signaling bits over six superframes
  task automatic send_mf(input logic [35:0] w);
    for (int i = 0; i < 36; i++) begin
      send(w[i], i % 6 == 5, i == 35);
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/test_tdo_rx_overhead.sv ----
// Self-checking bench for the T1 receive overhead block
`timescale 1ns/1ps
`default_nettype none
module test_tdo_rx_overhead
  import tdo_pkg::*;
;
  localparam int LIMIT = 20000;
  localparam logic [35:0] MF_OK = {8'h96, 8'hD3, 8'h5A, CARRIER_ALIGN};
  logic ref_clk, arst_n, t1_mode, esf_mode;
  logic cs_n, rd_n, wr_n, d_oe_n, int_n;
  logic [7:0] addr, d_in, d_out;
  tdo_ovh_t ovh;
  logic [7:0] regs [9];
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  tdo_rx_overhead i_tdo_rx_overhead (
    .ref_clk(ref_clk), .arst_n(arst_n), .t1_mode(t1_mode),
    .esf_mode(esf_mode), .ovh(ovh), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .d_in(d_in), .d_out(d_out),
    .d_oe_n(d_oe_n), .int_n(int_n)
  );
  tdo_line_model i_tdo_line_model (.ref_clk(ref_clk), .ovh(ovh));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking and closing
  task automatic stop_test();
    $display("checked %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic int_chk(input logic e);
    check({7'h00, int_n}, {7'h00, e});
  endtask
  task automatic done(input string name);
    $display("test done: %s", name);
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      $display("unexpected at %0t: run did not finish", $time);
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel port; strobes pass two sync flops, so hold them 4 cycles
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Strobes are {cs_n, rd_n, wr_n}
  task automatic drive_pins(input logic [2:0] s, input logic [7:0] a,
                            input logic [7:0] d);
    {cs_n, rd_n, wr_n} = s;
    addr = a;
    d_in = d;
  endtask
  task automatic set_mode(input logic t1, input logic esf);
    t1_mode = t1;
    esf_mode = esf;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    drive_pins(3'b010, a, d);
    idle(4);
    drive_pins(3'b011, a, d);
    idle(4);
    drive_pins(3'b111, a, d);
    idle(4);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] exp);
    @(negedge ref_clk);
    drive_pins(3'b001, a, d_in);
    idle(4);
    check({7'h00, d_oe_n}, 8'h00);
    check(d_out & m, exp);
    drive_pins(3'b111, a, d_in);
    idle(4);
    check({7'h00, d_oe_n}, 8'h01);
  endtask
  // One filter setting: need codes to detect, bits idle bits to clear
  task automatic code_filters(input logic [7:0] ctl, input int need,
                              input int bits);
    wr(ADDR_LSTAT7, 8'h0F);
    wr(ADDR_CODE_CTRL, ctl);
    wr(ADDR_CODE_CTRL, ctl | 8'h80);
    repeat (need - 1) i_tdo_line_model.send_code(6'h21);
    rdm(ADDR_LSTAT7, 8'h03, 8'h00);
    i_tdo_line_model.send_code(6'h21);
    rdm(ADDR_LSTAT7, 8'h03, 8'h01);
    i_tdo_line_model.send_zeros(bits - 1);
    rdm(ADDR_LSTAT7, 8'h03, 8'h01);
    i_tdo_line_model.send_zeros(1);
    rdm(ADDR_LSTAT7, 8'h03, 8'h03);
    wr(ADDR_LSTAT7, 8'h03);
    repeat (need) i_tdo_line_model.send_code(6'h21);
    rdm(ADDR_LSTAT7, 8'h01, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    arst_n = 1'b0;
    set_mode(1'b1, 1'b1);
    drive_pins(3'b111, 8'h00, 8'h00);
    regs = '{ADDR_CODE_CTRL, ADDR_DL_SHIFT, ADDR_CODE_VAL, ADDR_CARRIER_1,
             ADDR_CARRIER_2, ADDR_CARRIER_3, ADDR_LSTAT7, ADDR_IMASK7, 8'h20};
    idle(20);
    arst_n = 1'b1;
    idle(3);
    foreach (regs[i]) rdm(regs[i], 8'hFF, RST_BYTE);
    int_chk(1'b1);
    done("reset values");

    wr(ADDR_CODE_CTRL, 8'h7F);
    rdm(ADDR_CODE_CTRL, 8'hFF, 8'h36);
    wr(ADDR_CODE_VAL, 8'hFF);
    rdm(ADDR_CODE_VAL, 8'hFF, 8'h00);
    wr(8'h20, 8'hFF);
    rdm(8'h20, 8'hFF, 8'h00);
    wr(ADDR_IMASK7, 8'h0F);
    rdm(ADDR_IMASK7, 8'hFF, 8'h0F);
    done("register access");

    // Five ones then a zero would lose a bit if destuffed
    i_tdo_line_model.send_byte(8'h5F);
    rdm(ADDR_DL_SHIFT, 8'hFF, 8'h5F);
    rdm(ADDR_LSTAT7, 8'hFF, 8'h04);
    int_chk(1'b0);
    rdm(ADDR_LSTAT7, 8'hFF, 8'h04);
    wr(ADDR_LSTAT7, 8'h04);
    rdm(ADDR_LSTAT7, 8'hFF, 8'h00);
    int_chk(1'b1);
    done("data link shift");

    wr(ADDR_IMASK7, 8'h03);
    wr(ADDR_CODE_CTRL, 8'h02);
    wr(ADDR_CODE_CTRL, 8'h82);
    repeat (2) i_tdo_line_model.send_code(6'h13);
    rdm(ADDR_LSTAT7, 8'h03, 8'h00);
    int_chk(1'b1);
    i_tdo_line_model.send_code(6'h13);
    rdm(ADDR_LSTAT7, 8'h03, 8'h01);
    rdm(ADDR_CODE_VAL, 8'hFF, 8'h13);
    int_chk(1'b0);
    wr(ADDR_LSTAT7, 8'h01);
    rdm(ADDR_LSTAT7, 8'h03, 8'h00);
    int_chk(1'b1);
    i_tdo_line_model.send_zeros(15);
    rdm(ADDR_LSTAT7, 8'h03, 8'h00);
    i_tdo_line_model.send_zeros(1);
    rdm(ADDR_LSTAT7, 8'h03, 8'h02);
    int_chk(1'b0);
    wr(ADDR_LSTAT7, 8'h03);
    done("code detect and clear");

    // New filter is only pending until the next detector reset
    wr(ADDR_CODE_CTRL, 8'h00);
    i_tdo_line_model.send_code(6'h2D);
    rdm(ADDR_LSTAT7, 8'h01, 8'h00);
    wr(ADDR_CODE_CTRL, 8'h80);
    set_mode(1'b0, 1'b1);
    i_tdo_line_model.send_code(6'h2D);
    rdm(ADDR_LSTAT7, 8'h01, 8'h00);
    set_mode(1'b1, 1'b1);
    i_tdo_line_model.send_code(6'h2D);
    rdm(ADDR_LSTAT7, 8'h01, 8'h01);
    rdm(ADDR_CODE_VAL, 8'hFF, 8'h2D);
    wr(ADDR_LSTAT7, 8'h03);
    i_tdo_line_model.send_code(6'h0E);
    rdm(ADDR_CODE_VAL, 8'hFF, 8'h2D);
    rdm(ADDR_LSTAT7, 8'h01, 8'h00);
    done("detector reset and settings");

    code_filters(8'h12, 3, 32);
    code_filters(8'h24, 5, 48);
    code_filters(8'h36, 7, 64);
    done("filter and clear settings");

    // superframe framing for the carrier link
    set_mode(1'b1, 1'b0);
    wr(ADDR_LSTAT7, 8'h0F);
    wr(ADDR_IMASK7, 8'h08);
    i_tdo_line_model.send_mf(MF_OK);
    rdm(ADDR_LSTAT7, 8'h0C, 8'h0C);
    int_chk(1'b0);
    rdm(ADDR_CARRIER_1, 8'hFF, MF_OK[19:12]);
    rdm(ADDR_CARRIER_2, 8'hFF, MF_OK[27:20]);
    rdm(ADDR_CARRIER_3, 8'hFF, MF_OK[35:28]);
    rdm(ADDR_DL_SHIFT, 8'hFF, {2'b00, MF_OK[35:30]});
    wr(ADDR_LSTAT7, 8'h0F);
    i_tdo_line_model.send_mf(MF_OK ^ 36'h0_0000_0F0F);
    rdm(ADDR_LSTAT7, 8'h08, 8'h00);
    int_chk(1'b1);
    rdm(ADDR_CARRIER_1, 8'hFF, MF_OK[19:12]);
    done("carrier multiframe");
    stop_test();
  end
endmodule
`default_nettype wire
